//--- core/cgh_top.sv
module cgh_top #(
  parameter int CW = cgh_pkg::CHROMA_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // chroma input stream (signed u and v)
  input wire logic [CW-1:0] pix_u,
  input wire logic [CW-1:0] pix_v,
  input wire logic pix_valid,
  output logic pix_ready,
  // chroma output stream
  output logic [CW-1:0] out_u,
  output logic [CW-1:0] out_v,
  output logic out_valid,
  input wire logic out_ready,
  // scaler settings
  output logic [15:0] horizontal_scale,
  output logic [7:0] horizontal_delay
);
  localparam int GW = cgh_pkg::GAIN_W;
  localparam int PW = CW + GW + 1;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] chroma_u_gain_low_r, chroma_u_gain_low_nxt;
  logic [7:0] chroma_v_gain_low_r, chroma_v_gain_low_nxt;
  logic [1:0] gain_msb_r, gain_msb_nxt;
  logic [15:0] horiz_scale_r, horiz_scale_nxt;
  logic [7:0] horiz_delay_r, horiz_delay_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [GW-1:0] chroma_u_gain, chroma_v_gain;
  logic do_write, wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;

  // gain is msb over low byte
  assign chroma_u_gain = {gain_msb_r[cgh_pkg::MSB_U_BIT], chroma_u_gain_low_r};
  assign chroma_v_gain = {gain_msb_r[cgh_pkg::MSB_V_BIT], chroma_v_gain_low_r};

  assign do_write = aw_have_r && w_have_r && !bvalid_r;

  always_comb begin
    chroma_u_gain_low_nxt = chroma_u_gain_low_r;
    chroma_v_gain_low_nxt = chroma_v_gain_low_r;
    gain_msb_nxt = gain_msb_r;
    horiz_scale_nxt = horiz_scale_r;
    horiz_delay_nxt = horiz_delay_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    wr_hit = 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      if (awaddr_r == cgh_pkg::OFF_U_GAIN_LOW) begin
        if (wstrb_r[0]) chroma_u_gain_low_nxt = wdata_r[7:0];
      end else if (awaddr_r == cgh_pkg::OFF_V_GAIN_LOW) begin
        if (wstrb_r[0]) chroma_v_gain_low_nxt = wdata_r[7:0];
      end else if (awaddr_r == cgh_pkg::OFF_GAIN_MSB) begin
        if (wstrb_r[0]) gain_msb_nxt = wdata_r[1:0];
      end else if (awaddr_r == cgh_pkg::OFF_HORIZ_SCALE) begin
        if (wstrb_r[0]) horiz_scale_nxt[7:0] = wdata_r[7:0];
        if (wstrb_r[1]) horiz_scale_nxt[15:8] = wdata_r[15:8];
      end else if (awaddr_r == cgh_pkg::OFF_HORIZ_DELAY) begin
        if (wstrb_r[0]) horiz_delay_nxt = wdata_r[7:0];
      end else if (awaddr_r == cgh_pkg::OFF_STATUS) begin
        wr_hit = 1'b1;
      end else begin
        wr_hit = 1'b0;
      end
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? cgh_pkg::RESP_OKAY : cgh_pkg::RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == cgh_pkg::OFF_U_GAIN_LOW) begin
      rd_val[7:0] = chroma_u_gain_low_r;
    end else if (s_axi_araddr == cgh_pkg::OFF_V_GAIN_LOW) begin
      rd_val[7:0] = chroma_v_gain_low_r;
    end else if (s_axi_araddr == cgh_pkg::OFF_GAIN_MSB) begin
      rd_val[1:0] = gain_msb_r;
    end else if (s_axi_araddr == cgh_pkg::OFF_HORIZ_SCALE) begin
      rd_val[15:0] = horiz_scale_r;
    end else if (s_axi_araddr == cgh_pkg::OFF_HORIZ_DELAY) begin
      rd_val[7:0] = horiz_delay_r;
    end else if (s_axi_araddr == cgh_pkg::OFF_STATUS) begin
      rd_val[0] = out_valid;
      rd_val[1] = pix_ready;
    end else begin
      rd_hit = 1'b0;
    end
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_val;
      rresp_nxt = rd_hit ? cgh_pkg::RESP_OKAY : cgh_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chroma_u_gain_low_r <= cgh_pkg::RST_U_GAIN_LOW;
      chroma_v_gain_low_r <= cgh_pkg::RST_V_GAIN_LOW;
      gain_msb_r <= 2'h0;
      horiz_scale_r <= cgh_pkg::RST_HORIZ_SCALE;
      horiz_delay_r <= cgh_pkg::RST_HORIZ_DELAY;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      chroma_u_gain_low_r <= chroma_u_gain_low_nxt;
      chroma_v_gain_low_r <= chroma_v_gain_low_nxt;
      gain_msb_r <= gain_msb_nxt;
      horiz_scale_r <= horiz_scale_nxt;
      horiz_delay_r <= horiz_delay_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_arready = arready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign horizontal_scale = horiz_scale_r;
  assign horizontal_delay = horiz_delay_r;

  ////////////////////////////////////////////////////////////////////////////
  // gain: signed chroma times gain / 128, saturated
  function automatic logic [CW-1:0] apply_gain(input logic [CW-1:0] c, input logic [GW-1:0] g);
    logic signed [PW-1:0] p;
    logic signed [PW-1:0] hi;
    logic signed [PW-1:0] lo;
    p = (PW'(signed'(c)) * signed'({1'b0, g})) >>> cgh_pkg::GAIN_SHIFT;
    hi = PW'((1 << (CW - 1)) - 1);
    lo = -PW'(1 << (CW - 1));
    if (p > hi) begin
      apply_gain = hi[CW-1:0];
    end else if (p < lo) begin
      apply_gain = lo[CW-1:0];
    end else begin
      apply_gain = p[CW-1:0];
    end
  endfunction

  logic [2*CW-1:0] gained;
  assign gained = {apply_gain(pix_u, chroma_u_gain), apply_gain(pix_v, chroma_v_gain)};

  logic [2*CW-1:0] buf_out;
  cgh_skid #(.WIDTH(2 * CW)) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(gained),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .out_data(buf_out),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );
  assign out_u = buf_out[2*CW-1:CW];
  assign out_v = buf_out[CW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_V_RESET: assert property (@(posedge aclk)
    !aresetn |=> chroma_v_gain_low_r == cgh_pkg::RST_V_GAIN_LOW)
    else $error("v gain reset value wrong");
  AST_U_RESET: assert property (@(posedge aclk)
    !aresetn |=> chroma_u_gain_low_r == cgh_pkg::RST_U_GAIN_LOW)
    else $error("u gain reset value wrong");
  AST_V_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_r == cgh_pkg::OFF_V_GAIN_LOW && wstrb_r[0]
    |=> chroma_v_gain_low_r == $past(wdata_r[7:0]))
    else $error("v gain write lost");
  AST_U_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_r == cgh_pkg::OFF_U_GAIN_LOW && wstrb_r[0]
    |=> chroma_u_gain_low_r == $past(wdata_r[7:0]))
    else $error("u gain write lost");
  AST_V_UNITY: assert property (@(posedge aclk) disable iff (!aresetn)
    chroma_v_gain == 9'h080 |-> gained[CW-1:0] == pix_v)
    else $error("unity v gain changed data");
  AST_V_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    chroma_v_gain == 9'h000 |-> gained[CW-1:0] == '0)
    else $error("zero v gain not zero");
  AST_U_UNITY: assert property (@(posedge aclk) disable iff (!aresetn)
    chroma_u_gain == 9'h080 |-> gained[2*CW-1:CW] == pix_u)
    else $error("unity u gain changed data");
  AST_MSB_CONCAT: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_r == cgh_pkg::OFF_GAIN_MSB && wstrb_r[0]
    |=> {chroma_v_gain[GW-1], chroma_u_gain[GW-1]} == $past(wdata_r[1:0]))
    else $error("gain msb not concatenated");
  AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped");
  COV_V_WRITE: cover property (@(posedge aclk) do_write && awaddr_r == cgh_pkg::OFF_V_GAIN_LOW);
  COV_READ: cover property (@(posedge aclk) rvalid_r && s_axi_rready);
  COV_STALL: cover property (@(posedge aclk) !pix_ready && pix_valid);
endmodule

//--- core/cgh_pkg.sv
package cgh_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_U_GAIN_LOW = 12'h034;
  localparam logic [11:0] OFF_V_GAIN_LOW = 12'h038;
  localparam logic [11:0] OFF_GAIN_MSB = 12'h03c;
  localparam logic [11:0] OFF_HORIZ_SCALE = 12'h040;
  localparam logic [11:0] OFF_HORIZ_DELAY = 12'h044;
  localparam logic [11:0] OFF_STATUS = 12'h048;
  // reset values
  localparam logic [7:0] RST_U_GAIN_LOW = 8'hfe;
  localparam logic [7:0] RST_V_GAIN_LOW = 8'hb4;
  localparam logic [15:0] RST_HORIZ_SCALE = 16'h0000;
  localparam logic [7:0] RST_HORIZ_DELAY = 8'h80;
  // msb register field positions
  localparam int MSB_U_BIT = 0;
  localparam int MSB_V_BIT = 1;
  // gain encoding: gain / 128
  localparam int GAIN_W = 9;
  localparam int GAIN_SHIFT = 7;
  localparam int CHROMA_W = 8;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- core/cgh_skid.sv
module cgh_skid #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // two-entry buffer: entry 0 is the head
  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;
  logic in_ready_r;
  logic in_ready_nxt;
  logic out_valid_r;
  logic out_valid_nxt;

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem_r[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    cnt_nxt = cnt_r;
    if (pop) begin
      mem_nxt[0] = mem_r[1];
    end
    if (push) begin
      if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
        mem_nxt[0] = in_data;
      end else begin
        mem_nxt[1] = in_data;
      end
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
    in_ready_nxt = (cnt_nxt != 2'h2);
    out_valid_nxt = (cnt_nxt != 2'h0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 2'h0;
      in_ready_r <= 1'b1;
      out_valid_r <= 1'b0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready_r <= in_ready_nxt;
      out_valid_r <= out_valid_nxt;
      mem_r <= mem_nxt;
    end
  end

  AST_SKID_NO_OVERFLOW: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_r == 2'h2 |-> !in_ready)
    else $error("buffer full but ready high");
endmodule

//--- bench/chroma_gain_horizontal_scale_config_tb_top.sv
module chroma_gain_horizontal_scale_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] pix_u = 8'h00, pix_v = 8'h00, out_u, out_v, horiz_delay;
  logic pix_valid = 1'b0, out_ready = 1'b0, pix_ready, out_valid, stall = 1'b0;
  logic [15:0] horiz_scale;
  logic [31:0] seed = 32'hd3c9, rs = 32'hd3c9, d;
  logic [1:0] r;
  logic [15:0] q[$];
  int gu = 'h0fe, gv = 'h0b4, n_fail = 0, checked = 0;
  int gtab[4][2] = '{'{'h080, 'h080}, '{'h0b4, 'h1ff}, '{'h0ff, 'h000}, '{'h17f, 'h001}};

  cgh_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pix_u(pix_u), .pix_v(pix_v), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .out_u(out_u), .out_v(out_v), .out_valid(out_valid), .out_ready(out_ready),
    .horizontal_scale(horiz_scale), .horizontal_delay(horiz_delay));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] sat(input logic [7:0] p, input int g);
    int x;
    x = ($signed(p) * g) >>> 7;
    if (x > 127) x = 127;
    if (x < -128) x = -128;
    return x[7:0];
  endfunction

  task automatic tally_and_finish;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      n_fail++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(i, 50);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(i, 50);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic send(input int n);
    int k, i;
    @(posedge aclk);
    for (k = 0; k < n; k++) begin
      seed = nx(seed);
      pix_u <= seed[7:0];
      pix_v <= seed[15:8];
      pix_valid <= 1'b1;
      for (i = 0; i < 100; i++) begin
        @(posedge aclk);
        if (pix_ready) break;
      end
      tmo(i, 100);
    end
    pix_valid <= 1'b0;
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (q.size() == 0) break;
    end
    tmo(i, 200);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // random receiver stalls and output scoreboard
  always @(posedge aclk) begin
    rs <= nx(rs);
    out_ready <= !stall && rs[3];
    if (out_valid && out_ready) begin
      if (q.size() == 0) cmp(32'h1, 32'h0, "unexpected pixel");
      else cmp({out_u, out_v}, q.pop_front(), "pixel");
    end
    if (pix_valid && pix_ready) q.push_back({sat(pix_u, gu), sat(pix_v, gv)});
  end

  initial begin
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cgh_pkg::OFF_U_GAIN_LOW, d, r);
    cmp(d, 32'h000000fe, "u low reset");
    cmp({30'h0, r}, {30'h0, cgh_pkg::RESP_OKAY}, "read resp");
    rd(cgh_pkg::OFF_V_GAIN_LOW, d, r);
    cmp(d, 32'h000000b4, "v low reset");
    rd(cgh_pkg::OFF_GAIN_MSB, d, r);
    cmp(d, 32'h0, "msb reset");
    cmp({24'h0, horiz_delay}, 32'h00000080, "delay reset");
    cmp({16'h0, horiz_scale}, 32'h00000000, "scale reset");
    send(8);
    drain();
    for (int t = 0; t < 4; t++) begin
      wr(cgh_pkg::OFF_U_GAIN_LOW, {24'hfff5a0, gtab[t][0][7:0]}, r);
      cmp({30'h0, r}, {30'h0, cgh_pkg::RESP_OKAY}, "write resp");
      wr(cgh_pkg::OFF_V_GAIN_LOW, {24'h0, gtab[t][1][7:0]}, r);
      wr(cgh_pkg::OFF_GAIN_MSB, {30'h0, gtab[t][1][8], gtab[t][0][8]}, r);
      gu = gtab[t][0];
      gv = gtab[t][1];
      rd(cgh_pkg::OFF_U_GAIN_LOW, d, r);
      cmp(d, {24'h0, gtab[t][0][7:0]}, "u low readback");
      rd(cgh_pkg::OFF_V_GAIN_LOW, d, r);
      cmp(d, {24'h0, gtab[t][1][7:0]}, "v low readback");
      send(10);
      drain();
    end
    stall <= 1'b1;
    send(2);
    repeat (2) @(posedge aclk);
    cmp({31'h0, pix_ready}, 32'h0, "buffer full");
    cmp({31'h0, out_valid}, 32'h1, "held output");
    stall <= 1'b0;
    drain();
    rd(cgh_pkg::OFF_STATUS, d, r);
    cmp(d, 32'h00000002, "status idle");
    wr(cgh_pkg::OFF_HORIZ_SCALE, 32'h00001234, r);
    wr(cgh_pkg::OFF_HORIZ_DELAY, 32'h00000040, r);
    rd(cgh_pkg::OFF_HORIZ_SCALE, d, r);
    cmp(d, 32'h00001234, "scale readback");
    cmp({16'h0, horiz_scale}, 32'h00001234, "scale port");
    cmp({24'h0, horiz_delay}, 32'h00000040, "delay port");
    rd(12'h100, d, r);
    cmp({30'h0, r}, {30'h0, cgh_pkg::RESP_SLVERR}, "unmapped read resp");
    cmp(d, 32'h0, "unmapped read data");
    wr(12'h100, 32'h0, r);
    cmp({30'h0, r}, {30'h0, cgh_pkg::RESP_SLVERR}, "unmapped write");
    wr(cgh_pkg::OFF_STATUS, 32'hffffffff, r);
    cmp({30'h0, r}, {30'h0, cgh_pkg::RESP_OKAY}, "status write");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cgh_pkg::OFF_U_GAIN_LOW, d, r);
    cmp(d, 32'h000000fe, "u low after reset");
    rd(cgh_pkg::OFF_V_GAIN_LOW, d, r);
    cmp(d, 32'h000000b4, "v low after reset");
    cmp({24'h0, horiz_delay}, 32'h00000080, "delay after reset");
    tally_and_finish();
  end
endmodule
